/* rtl/touch_port_device.sv */
// Summary of operation
// - Host waits for ready line high first
// - Host starts transfer with select low
// - One byte, eight falling clock edges
// - Device updates data-out on falling edges
// - Both sides sample on rising edges
// - Host raises select after eighth clock
// - Device may drop ready after select
// - Reply comes out in next transfer
// - Ready rises 50-100 us after burst
// - Host selects within 10 us grace
// - Select to first clock 10-100 us
// - Select high one burst gap minimum
// - Clock period 10 to 1000 us
// - Ready window lasts at least 240 us
// - Gap 2-7 ms, stretched by long bursts
// - Gap from setup, default 3 ms
// - CRC8 LSB-first, reflected polynomial 0x8C
// - Ready within 150-160 us after wake
// - Cold start waits start-up plus recal
// - Three-bit gap setting, eight values
`timescale 1ns/1ps
`include "touch_port_params.svh"
module touch_port_device
    import touch_port_pkg::*;
#(
    parameter int unsigned COLD_CYCLES = `COLD_CYC,
    parameter int unsigned BURST_CYCLES = `BURST_CYC,
    parameter int unsigned US_CYCLES = `SYS_CLK_MHZ
) (
    // Core clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Link clock, made by the host
    input wire logic link_clk_i,
    // Link side
    touch_port_if.device link,
    // Core side
    input wire logic wake_i,
    input wire logic [7:0] reply_i,
    input wire logic [2:0] burst_gap_setting_i,
    input wire logic gap_setting_vld_i,
    input wire logic [15:0] burst_extra_us_i,
    output logic [7:0] rx_byte_o,
    output logic rx_vld_o,
    output logic [7:0] crc_o,
    output logic comm_ready_o,
    output logic bursting_o
);
    typedef enum logic [2:0] {ST_COLD, ST_WAKE, ST_BURST, ST_DELAY, ST_READY, ST_SPACE} core_st_t;
    core_st_t st;
    // Core timings follow the microsecond scale, so a shortened bench keeps their proportions
    localparam int unsigned DELAY_CYCLES = `RDY_DELAY_US * US_CYCLES;
    localparam int unsigned WINDOW_CYCLES = `RDY_WINDOW_MIN_US * US_CYCLES;
    localparam int unsigned WAKE_CYCLES = `WAKE_US * US_CYCLES;
    // Link-domain shift registers, clocked by the host clock
    logic [7:0] rx_sh;
    logic [2:0] bit_cnt;
    logic [7:0] tx_sh;
    logic rx_tgl;
    logic [7:0] rx_hold;
    logic ss_q1, ss_q2;
    logic tg_q1, tg_q2, tg_q3;
    logic [2:0] gap_sel;
    logic [31:0] cnt;
    logic [31:0] gap_left;
    logic [7:0] reply_hold;
    logic rdy_low;
    // Reply word settles in core domain only when select is high
    wire ss_high = ss_q2;
    wire rx_event = tg_q2 ^ tg_q3;
    // Spacing: setting plus any processing overrun stretches it
    wire [31:0] gap_cyc = 32'(gap_us(gap_sel) + burst_extra_us_i) * US_CYCLES;
    // Sampling on rising link clock while selected
    always_ff @(posedge link_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_sh <= 8'h00;
            bit_cnt <= 3'h0;
            rx_tgl <= 1'b0;
            rx_hold <= 8'h00;
        end else if (!link.ss_n) begin
            rx_sh <= {rx_sh[6:0], link.mosi};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                rx_hold <= {rx_sh[6:0], link.mosi};
                rx_tgl <= ~rx_tgl;
            end
        end
    end
    // Output shifting on falling link clock; the first fall of a byte loads the held reply
    // The reply word only moves while select is high, so the link side reads it settled
    always_ff @(negedge link_clk_i or posedge link.ss_n) begin
        if (link.ss_n) begin
            tx_sh <= 8'h00;
        end else if (bit_cnt == 3'h0) begin
            tx_sh <= reply_hold;
        end else begin
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end
    // Data out is low while deselected; the host never samples it then
    assign link.miso = link.ss_n ? 1'b0 : tx_sh[7];
    assign link.rdy_oe = rdy_low;
    // Synchronise select level and byte toggle into core domain
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ss_q1 <= 1'b1;
            ss_q2 <= 1'b1;
            tg_q1 <= 1'b0;
            tg_q2 <= 1'b0;
            tg_q3 <= 1'b0;
        end else begin
            ss_q1 <= link.ss_n;
            ss_q2 <= ss_q1;
            tg_q1 <= rx_tgl;
            tg_q2 <= tg_q1;
            tg_q3 <= tg_q2;
        end
    end
    // Received byte handed to the core, and the next reply latched
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_byte_o <= 8'h00;
            rx_vld_o <= 1'b0;
            reply_hold <= 8'h00;
            gap_sel <= `GAP_DEFAULT_SEL;
        end else begin
            rx_vld_o <= rx_event;
            if (rx_event) begin
                rx_byte_o <= rx_hold;
            end
            if (ss_high) begin
                reply_hold <= reply_i;
            end
            if (gap_setting_vld_i) begin
                gap_sel <= burst_gap_setting_i;
            end
        end
    end
    // Burst / ready sequencer
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= ST_COLD;
            cnt <= 32'h0;
            gap_left <= 32'h0;
            rdy_low <= 1'b1;
            comm_ready_o <= 1'b0;
            bursting_o <= 1'b0;
        end else begin
            cnt <= cnt + 32'h1;
            gap_left <= (gap_left != 32'h0) ? gap_left - 32'h1 : 32'h0;
            unique case (st)
                ST_COLD: begin
                    if (wake_i) begin
                        // Waking skips the cold wait and the first burst
                        st <= ST_WAKE;
                        cnt <= 32'h0;
                    end else if (cnt >= COLD_CYCLES - 1) begin
                        st <= ST_BURST;
                        cnt <= 32'h0;
                        gap_left <= gap_cyc;
                        bursting_o <= 1'b1;
                    end
                end
                ST_WAKE: begin
                    if (cnt >= WAKE_CYCLES - 1) begin
                        st <= ST_READY;
                        cnt <= 32'h0;
                        gap_left <= gap_cyc;
                        rdy_low <= 1'b0;
                        comm_ready_o <= 1'b1;
                    end
                end
                ST_BURST: begin
                    if (cnt >= BURST_CYCLES - 1) begin
                        st <= ST_DELAY;
                        cnt <= 32'h0;
                        bursting_o <= 1'b0;
                    end
                end
                ST_DELAY: begin
                    if (cnt >= DELAY_CYCLES - 1) begin
                        st <= ST_READY;
                        cnt <= 32'h0;
                        rdy_low <= 1'b0;
                        comm_ready_o <= 1'b1;
                    end
                end
                ST_READY: begin
                    // Hold the window at least its minimum, then close once selected or time is up
                    if (cnt >= WINDOW_CYCLES && (!ss_high || gap_left <= BURST_CYCLES)) begin
                        st <= ST_SPACE;
                        rdy_low <= 1'b1;
                        comm_ready_o <= 1'b0;
                    end
                end
                default: begin
                    // Wait out the spacing and any transfer in progress
                    if (gap_left == 32'h0 && ss_high) begin
                        st <= ST_BURST;
                        cnt <= 32'h0;
                        gap_left <= gap_cyc;
                        bursting_o <= 1'b1;
                    end
                end
            endcase
        end
    end
    // Running CRC over received setup bytes; cleared while the sequencer is in its cold state
    crc8_unit u_crc (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .clear_i(st == ST_COLD),
        .byte_vld_i(rx_event),
        .byte_i(rx_hold),
        .crc_o(crc_o)
    );
endmodule

/* rtl/touch_port_params.svh */
// Timing and coding constants of the touch-sensor serial host port
`ifndef TOUCH_PORT_PARAMS_SVH
`define TOUCH_PORT_PARAMS_SVH
`define SYS_CLK_MHZ 50
`define BYTE_BITS 8
`define CRC_POLY_RSH 8'h8C
`define CRC_INIT 8'h00
`define RDY_DELAY_MIN_US 50
`define RDY_DELAY_MAX_US 100
`define RDY_DELAY_US ((`RDY_DELAY_MIN_US + `RDY_DELAY_MAX_US) / 2)
`define RDY_WINDOW_MIN_US 240
`define RDY_WINDOW_CYC (`RDY_WINDOW_MIN_US * `SYS_CLK_MHZ)
`define GRACE_MAX_US 10
`define GRACE_CYC (`GRACE_MAX_US * `SYS_CLK_MHZ)
`define SS_TO_CLK_US 20
`define SS_TO_CLK_CYC (`SS_TO_CLK_US * `SYS_CLK_MHZ)
`define SCK_HALF_US 10
`define SCK_HALF_CYC (`SCK_HALF_US * `SYS_CLK_MHZ)
`define GAP_DEFAULT_SEL 3'h2
`define GAP_MIN_SEL 3'h0
`define BURST_US 2500
`define BURST_CYC (`BURST_US * `SYS_CLK_MHZ)
`define WAKE_US 155
`define WAKE_CYC (`WAKE_US * `SYS_CLK_MHZ)
`define STARTUP_MS 400
`define RECAL_MS 450
`define COLD_CYC ((`STARTUP_MS + `RECAL_MS) * 1000 * `SYS_CLK_MHZ)
`endif

/* rtl/touch_port_pkg.sv */
// Types of the touch-sensor serial port, used by the device end only
package touch_port_pkg;
    typedef enum logic [2:0] {
        GAP_2MS0, GAP_2MS5, GAP_3MS0, GAP_3MS5, GAP_4MS0, GAP_5MS0, GAP_6MS0, GAP_7MS0
    } burst_gap_setting_t;
    // Burst spacing in microseconds, ascending with the setting
    function automatic logic [15:0] gap_us(input logic [2:0] sel);
        logic [15:0] r;
        r = 16'h0000;
        case (sel)
            3'h0: r = 16'h07D0;
            3'h1: r = 16'h09C4;
            3'h2: r = 16'h0BB8;
            3'h3: r = 16'h0DAC;
            3'h4: r = 16'h0FA0;
            3'h5: r = 16'h1388;
            3'h6: r = 16'h1770;
            default: r = 16'h1B58;
        endcase
        return r;
    endfunction
endpackage

/* rtl/touch_port_if.sv */
// Four-wire link plus open-drain ready line between host and device
`timescale 1ns/1ps
interface touch_port_if;
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso;
    logic rdy_oe;
    // Open-drain ready line, pulled high when nobody sinks it
    wire comm_ready_line = ~rdy_oe;
    modport device (input sck, input ss_n, input mosi, output miso, output rdy_oe, input comm_ready_line);
    modport host (output sck, output ss_n, output mosi, input miso, input comm_ready_line);
endinterface

/* rtl/crc8_unit.sv */
// Byte-fed 8-bit setup CRC, one byte per request, LSB first
`timescale 1ns/1ps
`include "touch_port_params.svh"
module crc8_unit (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Control
    input wire logic clear_i,
    input wire logic byte_vld_i,
    input wire logic [7:0] byte_i,
    // Result
    output logic [7:0] crc_o
);
    logic [7:0] next_crc;
    // Eight shift steps unrolled combinationally; one byte per clock
    always_comb begin
        logic [7:0] c;
        logic [7:0] d;
        c = crc_o;
        d = byte_i;
        for (int i = 0; i < `BYTE_BITS; i++) begin
            if ((c[0] ^ d[0]) == 1'b1) begin
                c = (c >> 1) ^ `CRC_POLY_RSH;
            end else begin
                c = c >> 1;
            end
            d = d >> 1;
        end
        next_crc = c;
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            crc_o <= `CRC_INIT;
        end else if (clear_i) begin
            crc_o <= `CRC_INIT;
        end else if (byte_vld_i) begin
            crc_o <= next_crc;
        end
    end
endmodule

/* rtl/touch_port_host.sv */
// Host end: waits for ready, then clocks one byte out and in
`timescale 1ns/1ps
`include "touch_port_params.svh"
module touch_port_host (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Link side
    touch_port_if.host link,
    // User side
    input wire logic start_i,
    input wire logic [7:0] tx_byte_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rx_byte_o,
    output logic late_o
);
    typedef enum logic [2:0] {H_IDLE, H_WAIT, H_LEAD, H_LOW, H_HIGH, H_END} host_st_t;
    host_st_t st;
    logic r1, r2, m1, m2;
    logic [31:0] cnt;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] tx;
    logic sck, ss_n, mosi;
    assign link.sck = sck;
    assign link.ss_n = ss_n;
    assign link.mosi = mosi;
    // Synchronise ready line and returned data
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r1 <= 1'b0;
            r2 <= 1'b0;
            m1 <= 1'b0;
            m2 <= 1'b0;
        end else begin
            r1 <= link.comm_ready_line;
            r2 <= r1;
            m1 <= link.miso;
            m2 <= m1;
        end
    end
    // Transfer sequencer; one byte per start, MSB first
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= H_IDLE;
            cnt <= 32'h0;
            bits <= 4'h0;
            sh <= 8'h00;
            tx <= 8'h00;
            sck <= 1'b1;
            ss_n <= 1'b1;
            mosi <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rx_byte_o <= 8'h00;
            late_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            cnt <= cnt + 32'h1;
            unique case (st)
                H_IDLE: begin
                    if (start_i) begin
                        tx <= tx_byte_i;
                        busy_o <= 1'b1;
                        late_o <= 1'b0;
                        st <= H_WAIT;
                    end
                end
                H_WAIT: begin
                    if (r2) begin
                        ss_n <= 1'b0;
                        mosi <= tx[7];
                        cnt <= 32'h0;
                        bits <= 4'h0;
                        st <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    if (cnt >= `SS_TO_CLK_CYC - 1) begin
                        sck <= 1'b0;
                        cnt <= 32'h0;
                        st <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (cnt >= `SCK_HALF_CYC - 1) begin
                        sck <= 1'b1;
                        sh <= {sh[6:0], m2};
                        bits <= bits + 4'h1;
                        cnt <= 32'h0;
                        st <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (cnt >= `SCK_HALF_CYC - 1) begin
                        cnt <= 32'h0;
                        if (bits == 4'h8) begin
                            ss_n <= 1'b1;
                            rx_byte_o <= sh;
                            done_o <= 1'b1;
                            st <= H_END;
                        end else begin
                            sck <= 1'b0;
                            tx <= {tx[6:0], 1'b0};
                            mosi <= tx[6];
                            st <= H_LOW;
                        end
                    end
                end
                default: begin
                    // Stay deselected until the device closes this window
                    if (!r2) begin
                        busy_o <= 1'b0;
                        st <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

/* test/touch_port_props.sv */
// Checker for the serial link between host end and device end
`timescale 1ns/1ps
module touch_port_props #(
    parameter int US_CYCLES = 50
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Link signals
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic rdy_oe,
    input wire logic comm_ready_line
);
    localparam int LEAD_MIN = 500;
    localparam int LEAD_MAX = 5000;
    localparam int HALF_MIN = 250;
    localparam int HALF_MAX = 25000;
    localparam int WIN_MIN = 240 * US_CYCLES;
    logic sck_q;
    logic [3:0] nf;
    logic [31:0] hcnt;
    logic [31:0] scnt;
    logic [31:0] rcnt;
    wire sck_fell = sck_q & ~sck;
    wire mid_byte = (nf != 4'h0) && (nf != 4'h8);

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Clock history and falls seen in the current frame
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sck_q <= 1'b1;
            nf <= 4'h0;
        end else begin
            sck_q <= sck;
            nf <= ss_n ? 4'h0 : nf + {3'h0, sck_fell};
        end
    end

    // Level lengths; the half-period count saturates so a long idle never wraps short
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hcnt <= 32'h0;
            scnt <= 32'h0;
            rcnt <= 32'h0;
        end else begin
            hcnt <= (sck != sck_q) ? 32'h0 : hcnt + {31'h0, ~&hcnt};
            scnt <= ss_n ? 32'h0 : scnt + 32'h1;
            rcnt <= comm_ready_line ? rcnt + 32'h1 : 32'h0;
        end
    end

    a_sck_idle_high: assert property (ss_n |-> sck) else $error("clock moved outside a frame");
    a_lead_time: assert property (!ss_n && sck_fell && nf == 4'h0 |-> scnt >= LEAD_MIN && scnt <= LEAD_MAX)
        else $error("select to first clock out of range");
    a_clock_half: assert property (!ss_n && sck != sck_q && nf != 4'h0 |-> hcnt >= HALF_MIN && hcnt <= HALF_MAX)
        else $error("clock half period out of range");
    a_eight_falls: assert property ($rose(ss_n) |-> nf == 4'h8) else $error("frame without eight falls");
    a_mosi_steady_high: assert property (!ss_n && mid_byte && sck && sck_q |-> $stable(mosi))
        else $error("data in moved while clock high");
    a_miso_steady_high: assert property (!ss_n && mid_byte && sck && sck_q |-> $stable(miso))
        else $error("data out moved while clock high");
    a_ready_window_len: assert property ($fell(comm_ready_line) && ss_n |-> rcnt >= WIN_MIN)
        else $error("ready window too short");
    a_select_on_ready: assert property ($fell(ss_n) |-> $past(comm_ready_line))
        else $error("select without ready");

    c_frame: cover property ($rose(ss_n) && nf == 4'h8);
    c_ready: cover property ($fell(rdy_oe));
    c_ready_drop_sel: cover property ($fell(comm_ready_line) && !ss_n);
endmodule

/* test/tb_touch_sensor_spi_host_port.sv */
// Bench joining the host end and the device end of the touch-sensor serial port
`timescale 1ns/1ps
`include "touch_port_params.svh"
module tb_touch_sensor_spi_host_port;
    localparam int US = 5;
    localparam int BURST = 500;
    localparam int LIMIT = 90000;
    logic sys_clk_i;
    logic rstn_i;
    logic start;
    logic wake;
    logic [7:0] tx_byte;
    logic [7:0] reply;
    logic [2:0] gap_sel;
    logic gap_vld;
    logic busy;
    logic done;
    logic [7:0] host_rx;
    logic [7:0] dev_rx;
    logic dev_vld;
    logic [7:0] dev_crc;
    logic dev_ready;
    logic bursting;
    logic [7:0] dev_last;
    logic [7:0] exp_crc;
    int dev_cnt = 0;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int n;

    touch_port_if touch_port_if_i ();
    // Shortened cold wait and burst so the run stays short
    touch_port_device #(.COLD_CYCLES(2000), .BURST_CYCLES(BURST), .US_CYCLES(US)) touch_port_device_i (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .link_clk_i(touch_port_if_i.sck), .link(touch_port_if_i),
        .wake_i(wake), .reply_i(reply), .burst_gap_setting_i(gap_sel), .gap_setting_vld_i(gap_vld),
        .burst_extra_us_i(16'h0000), .rx_byte_o(dev_rx), .rx_vld_o(dev_vld), .crc_o(dev_crc),
        .comm_ready_o(dev_ready), .bursting_o(bursting));
    touch_port_host touch_port_host_i (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .link(touch_port_if_i), .start_i(start), .tx_byte_i(tx_byte),
        .busy_o(busy), .done_o(done), .rx_byte_o(host_rx), .late_o());
    touch_port_props #(.US_CYCLES(US)) touch_port_props_i (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sck(touch_port_if_i.sck), .ss_n(touch_port_if_i.ss_n),
        .mosi(touch_port_if_i.mosi), .miso(touch_port_if_i.miso), .rdy_oe(touch_port_if_i.rdy_oe),
        .comm_ready_line(touch_port_if_i.comm_ready_line));

    // 50 MHz system clock
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    // Reference CRC, LSB first with the reflected polynomial
    function automatic logic [7:0] crc_next(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ 8'h8C) : (r >> 1);
        end
        return r;
    endfunction

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        compares++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("BAD t=%0t %s %0d not in %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    task automatic complete_run();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Cycles until the next rising edge of the burst flag
    task automatic burst_rise(output int cnt);
        bit seen_low;
        cnt = 0;
        seen_low = 1'b0;
        while (!(seen_low && bursting === 1'b1) && cnt < 60000) begin
            seen_low = seen_low | (bursting === 1'b0);
            @(posedge sys_clk_i) #1;
            cnt++;
        end
    endtask

    // One byte each way; poke fires a second start while the first is running
    task automatic xfer(input logic [7:0] tx, input logic [7:0] rep, input bit poke);
        int k;
        k = 0;
        reply = rep;
        tx_byte = tx;
        start = 1'b1;
        @(posedge sys_clk_i) #1;
        start = 1'b0;
        chk1(busy, 1'b1, "host busy after start");
        if (poke) begin
            tx_byte = ~tx;
            start = 1'b1;
            @(posedge sys_clk_i) #1;
            start = 1'b0;
            tx_byte = tx;
        end
        while (touch_port_if_i.comm_ready_line !== 1'b1 && k < 40000) begin
            @(posedge sys_clk_i) #1;
            k++;
        end
        k = 0;
        while (touch_port_if_i.ss_n !== 1'b0 && k < 1000) begin
            @(posedge sys_clk_i) #1;
            k++;
        end
        chk_rng(k, 0, `GRACE_CYC, "select after ready");
        k = 0;
        while (done !== 1'b1 && k < 20000) begin
            @(posedge sys_clk_i) #1;
            k++;
        end
        repeat (10) @(posedge sys_clk_i) #1;
        exp_crc = crc_next(exp_crc, tx);
        chk8(host_rx, rep, "host reply");
        chk8(dev_last, tx, "device byte");
        chk8(dev_crc, exp_crc, "running crc");
        chk1(busy, 1'b0, "host idle once window closed");
    endtask

    // Bytes taken by the device, counted for refusal checks
    always @(posedge sys_clk_i) begin
        if (dev_vld === 1'b1) begin
            dev_last <= dev_rx;
            dev_cnt <= dev_cnt + 1;
        end
    end

    // Hang guard
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors++;
            $display("BAD t=%0t run timed out", $time);
            complete_run();
        end
    end

    initial begin
        rstn_i = 1'b0;
        start = 1'b0;
        wake = 1'b0;
        tx_byte = 8'h00;
        reply = 8'h00;
        gap_sel = 3'h0;
        gap_vld = 1'b0;
        exp_crc = 8'h00;
        repeat (3) @(posedge sys_clk_i);
        #1 rstn_i = 1'b1;
        chk1(touch_port_if_i.ss_n, 1'b1, "select idle");
        chk1(touch_port_if_i.sck, 1'b1, "clock idle");
        repeat (1500) @(posedge sys_clk_i) #1;
        chk1(touch_port_if_i.comm_ready_line, 1'b0, "ready low in cold wait");
        chk1(dev_ready, 1'b0, "ready flag low in cold wait");
        $display("test cold start done");
        burst_rise(n);
        burst_rise(n);
        chk_rng(n, 3000 * US, 3000 * US + BURST + 200, "default spacing");
        $display("test default spacing done");
        xfer(8'h80, 8'h01, 1'b1);
        xfer(8'h35, 8'hCA, 1'b0);
        $display("test transfers done");
        gap_sel = 3'h0;
        gap_vld = 1'b1;
        @(posedge sys_clk_i) #1;
        gap_vld = 1'b0;
        burst_rise(n);
        burst_rise(n);
        burst_rise(n);
        chk_rng(n, 2000 * US, 2000 * US + BURST + 200, "shortest spacing");
        chk_rng(dev_cnt, 2, 2, "bytes taken overall");
        $display("test spacing setting done");
        // Second reset in mid-run, then a wake that skips the cold wait
        rstn_i = 1'b0;
        repeat (3) @(posedge sys_clk_i) #1;
        rstn_i = 1'b1;
        chk1(touch_port_if_i.ss_n, 1'b1, "select idle after reset");
        chk1(touch_port_if_i.comm_ready_line, 1'b0, "ready low after reset");
        wake = 1'b1;
        @(posedge sys_clk_i) #1;
        wake = 1'b0;
        n = 0;
        while (touch_port_if_i.comm_ready_line !== 1'b1 && n < 2000) begin
            @(posedge sys_clk_i) #1;
            n++;
        end
        chk_rng(n, 150 * US, 160 * US, "ready after wake");
        chk1(dev_ready, 1'b1, "ready flag after wake");
        $display("test wake done");
        complete_run();
    end
endmodule
